// ---- pcitr_target.sv ----
// pcitr_target: target-side termination (retry, target abort) with read and write paths
// assumes the bus master keeps irdyn low while a data phase is pending; all on mclk
// Function
// - claim transaction with devseln in clock four
// - back-end requests retry: ready high, disconnect low
// - no strobe after a cycle with ready high
// - stopn low after disconnect low two cycles
// - master drops framen, then irdyn next cycle
// - release devseln and stopn as irdyn rises
// - target abort proceeds regardless of irdyn
// - back-end gives read data cycle after ready
// - read strobe cycle after ready asserted
// - trdyn two cycles after ready on reads
// - read data on ad with trdyn
// - abort request makes read data invalid
// - abort: devseln, trdyn high, stopn low next
// - after abort, stopn released as irdyn rises
// - retry when no ready within sixteen clocks
// - disconnect before any ready means retry
`timescale 1ns/10ps
`default_nettype none

module pcitr_fifo #(
  parameter int unsigned W = 32,
  parameter int unsigned D = 8
) (
  input  wire logic         mclk,
  input  wire logic         rstn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int unsigned AW = $clog2(D);
  localparam logic [AW:0] CNT_FULL = (AW+1)'(D);
  localparam logic [AW:0] CNT_ZERO = '0;
  localparam logic [AW-1:0] PTR_ONE = AW'(1);

  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          push, pop;

  always_comb begin
    in_ready  = (cnt_q != CNT_FULL);
    out_valid = (cnt_q != CNT_ZERO);
    out_data  = mem_q[rd_q];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    wr_d      = push ? wr_q + PTR_ONE : wr_q;
    rd_d      = pop ? rd_q + PTR_ONE : rd_q;
    cnt_d     = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= CNT_ZERO;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // storage needs no reset; occupancy guards every read
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule

module pcitr_target (
  input  wire logic                       mclk,
  input  wire logic                       rstn,
  pcitr_bus_if.target                     bus,
  input  wire logic                       local_target_ready_n,
  input  wire logic                       local_target_disconnect_req_n,
  input  wire logic                       local_abort_req_n,
  input  wire logic [pcitr_pkg::DATA_W-1:0] local_read_data_in,
  output logic                            local_transfer_strobe_n,
  output logic      [pcitr_pkg::DATA_W-1:0] local_write_data_out,
  output logic                            local_read_cycle
);
  import pcitr_pkg::*;

  pcitr_tgt_e        state_q, state_d;
  logic              devseln_q, devseln_d;
  logic              trdyn_q, trdyn_d;
  logic              stopn_q, stopn_d;
  logic              oe_q, oe_d;
  logic [DATA_W-1:0] ad_q, ad_d;
  logic              ad_oe_q, ad_oe_d;
  logic              strobe_n_q, strobe_n_d;
  logic [DATA_W-1:0] wdata_q, wdata_d;
  logic              read_q, read_d;
  logic              rdy1_q, rdy1_d;
  logic              disc1_q, disc1_d;
  logic              got_rdy_q, got_rdy_d;
  logic [TMR_W-1:0]  tmr_q, tmr_d;
  logic              f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  logic [DATA_W-1:0] f_out_data;
  logic              rdy, disc, abrt, phase_done;

  // write data is buffered so a slow back-end throttles trdyn instead of losing words
  pcitr_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_wr_fifo (
    .mclk      (mclk),
    .rstn      (rstn),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (bus.ad_mst),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  always_comb begin
    rdy        = !local_target_ready_n;
    disc       = !local_target_disconnect_req_n;
    abrt       = !local_abort_req_n;
    phase_done = (state_q == TGT_DATA) && !trdyn_q && !bus.irdyn;
    f_in_valid = phase_done && !read_q;
    // the back-end drains on its own ready; strobe never follows a high ready
    f_out_ready = f_out_valid && rdy && !read_q;
    state_d    = state_q;
    devseln_d  = devseln_q;
    trdyn_d    = 1'b1;
    stopn_d    = stopn_q;
    oe_d       = oe_q;
    ad_d       = ad_q;
    ad_oe_d    = 1'b0;
    strobe_n_d = 1'b1;
    wdata_d    = wdata_q;
    read_d     = read_q;
    rdy1_d     = 1'b0;
    disc1_d    = disc;
    got_rdy_d  = got_rdy_q;
    tmr_d      = tmr_q;
    case (state_q)
      TGT_IDLE: begin
        devseln_d = 1'b1;
        stopn_d   = 1'b1;
        oe_d      = 1'b0;
        got_rdy_d = 1'b0;
        tmr_d     = TMR_ZERO;
        if (!bus.framen) begin
          read_d  = bus.cmd_read;
          tmr_d   = TMR_ONE;
          state_d = TGT_DECODE;
        end
      end
      TGT_DECODE: begin
        // slow decode: sit out clock two so the claim lands in clock four
        tmr_d = tmr_q + TMR_ONE;
        if (tmr_q != TMR_ONE) begin
          devseln_d = 1'b0;
          oe_d      = 1'b1;
          state_d   = TGT_DATA;
        end
      end
      TGT_DATA: begin
        if (rdy) begin
          got_rdy_d = 1'b1;
        end else if (!got_rdy_q) begin
          tmr_d = tmr_q + TMR_ONE;
        end
        if (abrt) begin
          devseln_d = 1'b1;
          stopn_d   = 1'b0;
          state_d   = TGT_ABORT;
        end else if (bus.framen) begin
          // framen high here means the master took the word and raised irdyn with it: drop off the bus a cycle later
          devseln_d = 1'b1;
          stopn_d   = 1'b1;
          state_d   = TGT_TURN;
        end else if ((disc && disc1_q) || (!got_rdy_q && !rdy && tmr_q == TMR_LIMIT)) begin
          // a disconnect before any ready is a retry; so is a silent back-end
          stopn_d = 1'b0;
          state_d = TGT_STOP;
        end else if (read_q) begin
          rdy1_d     = rdy;
          strobe_n_d = !rdy;
          trdyn_d    = !rdy1_q;
          ad_oe_d    = 1'b1;
          if (rdy1_q) begin
            ad_d = local_read_data_in;
          end
        end else begin
          trdyn_d = !(rdy && f_in_ready);
        end
      end
      TGT_STOP: begin
        if (bus.framen) begin
          devseln_d = 1'b1;
          stopn_d   = 1'b1;
          state_d   = TGT_TURN;
        end
      end
      TGT_ABORT: begin
        // irdyn is not consulted here; only the master's framen ends it
        if (bus.framen) begin
          stopn_d = 1'b1;
          state_d = TGT_TURN;
        end
      end
      TGT_TURN: begin
        oe_d    = 1'b0;
        state_d = TGT_IDLE;
      end
      default: begin
        state_d = TGT_IDLE;
      end
    endcase
    // abort kills the read pipeline at once: stale back-end data never reaches ad
    if (abrt && read_q) begin
      rdy1_d     = 1'b0;
      strobe_n_d = 1'b1;
    end
    if (f_out_ready) begin
      strobe_n_d = 1'b0;
      wdata_d    = f_out_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_q    <= TGT_IDLE;
      devseln_q  <= 1'b1;
      trdyn_q    <= 1'b1;
      stopn_q    <= 1'b1;
      oe_q       <= 1'b0;
      ad_q       <= DATA_ZERO;
      ad_oe_q    <= 1'b0;
      strobe_n_q <= 1'b1;
      wdata_q    <= DATA_ZERO;
      read_q     <= 1'b0;
      rdy1_q     <= 1'b0;
      disc1_q    <= 1'b0;
      got_rdy_q  <= 1'b0;
      tmr_q      <= TMR_ZERO;
    end else begin
      state_q    <= state_d;
      devseln_q  <= devseln_d;
      trdyn_q    <= trdyn_d;
      stopn_q    <= stopn_d;
      oe_q       <= oe_d;
      ad_q       <= ad_d;
      ad_oe_q    <= ad_oe_d;
      strobe_n_q <= strobe_n_d;
      wdata_q    <= wdata_d;
      read_q     <= read_d;
      rdy1_q     <= rdy1_d;
      disc1_q    <= disc1_d;
      got_rdy_q  <= got_rdy_d;
      tmr_q      <= tmr_d;
    end
  end

  assign bus.devseln              = devseln_q;
  assign bus.trdyn                = trdyn_q;
  assign bus.stopn                = stopn_q;
  assign bus.tgt_oe               = oe_q;
  assign bus.ad_tgt               = ad_q;
  assign bus.ad_tgt_oe            = ad_oe_q;
  assign local_transfer_strobe_n  = strobe_n_q;
  assign local_write_data_out     = wdata_q;
  assign local_read_cycle         = read_q;
endmodule
`default_nettype wire

// ---- pcitr_pkg.sv ----
// pcitr_pkg: shared constants and types for the target retry/abort block
// assumes one 25 MHz clock (mclk) on both ends and a synchronous active-low reset
package pcitr_pkg;

  localparam int unsigned DATA_W     = 32;
  localparam int unsigned FIFO_DEPTH = 8;

  // no first ready within this many clocks after framen forces a retry
  localparam int unsigned RETRY_CLKS = 16;
  localparam int unsigned TMR_W      = 5;
  localparam logic [TMR_W-1:0] TMR_ZERO  = 5'h00;
  localparam logic [TMR_W-1:0] TMR_ONE   = 5'h01;
  localparam logic [TMR_W-1:0] TMR_LIMIT = TMR_W'(RETRY_CLKS - 1);

  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  // termination status reported to the master's user
  localparam logic [1:0] ST_NORMAL = 2'h0;
  localparam logic [1:0] ST_RETRY  = 2'h1;
  localparam logic [1:0] ST_ABORT  = 2'h2;

  typedef enum logic [2:0] {
    TGT_IDLE   = 3'b000,
    TGT_DECODE = 3'b001,
    TGT_DATA   = 3'b010,
    TGT_STOP   = 3'b011,
    TGT_ABORT  = 3'b100,
    TGT_TURN   = 3'b101
  } pcitr_tgt_e;

  typedef enum logic [2:0] {
    MST_IDLE = 3'b000,
    MST_ADDR = 3'b001,
    MST_DATA = 3'b010,
    MST_ENDF = 3'b011,
    MST_ENDI = 3'b100
  } pcitr_mst_e;

endpackage

// ---- pcitr_bus_if.sv ----
// pcitr_bus_if: the PCI-side wires between the master end and the target end
// assumes both ends run on the same mclk; each end drives its own wires, so none are shared
`timescale 1ns/10ps
`default_nettype none
interface pcitr_bus_if;
  import pcitr_pkg::*;
  logic              framen;
  logic              irdyn;
  logic              cmd_read;
  logic [DATA_W-1:0] ad_mst;
  logic              ad_mst_oe;
  logic              devseln;
  logic              trdyn;
  logic              stopn;
  logic              tgt_oe;
  logic [DATA_W-1:0] ad_tgt;
  logic              ad_tgt_oe;

  modport master (output framen, irdyn, cmd_read, ad_mst, ad_mst_oe,
                  input devseln, trdyn, stopn, tgt_oe, ad_tgt, ad_tgt_oe);
  modport target (input framen, irdyn, cmd_read, ad_mst, ad_mst_oe,
                  output devseln, trdyn, stopn, tgt_oe, ad_tgt, ad_tgt_oe);
endinterface
`default_nettype wire

// ---- pcitr_master.sv ----
// pcitr_master: minimal PCI bus master issuing single-word reads and writes
// assumes the target end on the same mclk; one request in flight at a time
`timescale 1ns/10ps
`default_nettype none
module pcitr_master (
  input  wire logic                         mclk,
  input  wire logic                         rstn,
  pcitr_bus_if.master                       bus,
  input  wire logic                         req,
  input  wire logic                         req_read,
  input  wire logic [pcitr_pkg::DATA_W-1:0] req_addr,
  input  wire logic [pcitr_pkg::DATA_W-1:0] req_wdata,
  output logic                              busy,
  output logic                              done,
  output logic      [1:0]                   status,
  output logic      [pcitr_pkg::DATA_W-1:0] rdata
);
  import pcitr_pkg::*;

  pcitr_mst_e        state_q, state_d;
  logic              framen_q, framen_d;
  logic              irdyn_q, irdyn_d;
  logic              read_q, read_d;
  logic [DATA_W-1:0] ad_q, ad_d;
  logic              ad_oe_q, ad_oe_d;
  logic [DATA_W-1:0] wdata_q, wdata_d;
  logic              busy_q, busy_d;
  logic              done_q, done_d;
  logic [1:0]        status_q, status_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;

  always_comb begin
    state_d  = state_q;
    framen_d = framen_q;
    irdyn_d  = irdyn_q;
    read_d   = read_q;
    ad_d     = ad_q;
    ad_oe_d  = ad_oe_q;
    wdata_d  = wdata_q;
    busy_d   = busy_q;
    done_d   = 1'b0;
    status_d = status_q;
    rdata_d  = rdata_q;
    case (state_q)
      MST_IDLE: begin
        if (req) begin
          framen_d = 1'b0;
          read_d   = req_read;
          ad_d     = req_addr;
          ad_oe_d  = 1'b1;
          wdata_d  = req_wdata;
          busy_d   = 1'b1;
          state_d  = MST_ADDR;
        end
      end
      MST_ADDR: begin
        irdyn_d = 1'b0;
        ad_d    = wdata_q;
        ad_oe_d = !read_q;
        state_d = MST_DATA;
      end
      MST_DATA: begin
        if (!bus.stopn) begin
          // stop always wins: no word is taken even with trdyn low, then frame down first
          framen_d = 1'b1;
          status_d = bus.devseln ? ST_ABORT : ST_RETRY;
          state_d  = MST_ENDF;
        end else if (!bus.trdyn && !bus.devseln) begin
          if (read_q) begin
            rdata_d = bus.ad_tgt;
          end
          framen_d = 1'b1;
          irdyn_d  = 1'b1;
          ad_oe_d  = 1'b0;
          status_d = ST_NORMAL;
          state_d  = MST_ENDI;
        end
      end
      MST_ENDF: begin
        irdyn_d = 1'b1;
        ad_oe_d = 1'b0;
        state_d = MST_ENDI;
      end
      MST_ENDI: begin
        busy_d  = 1'b0;
        done_d  = 1'b1;
        state_d = MST_IDLE;
      end
      default: begin
        state_d = MST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_q  <= MST_IDLE;
      framen_q <= 1'b1;
      irdyn_q  <= 1'b1;
      read_q   <= 1'b0;
      ad_q     <= DATA_ZERO;
      ad_oe_q  <= 1'b0;
      wdata_q  <= DATA_ZERO;
      busy_q   <= 1'b0;
      done_q   <= 1'b0;
      status_q <= ST_NORMAL;
      rdata_q  <= DATA_ZERO;
    end else begin
      state_q  <= state_d;
      framen_q <= framen_d;
      irdyn_q  <= irdyn_d;
      read_q   <= read_d;
      ad_q     <= ad_d;
      ad_oe_q  <= ad_oe_d;
      wdata_q  <= wdata_d;
      busy_q   <= busy_d;
      done_q   <= done_d;
      status_q <= status_d;
      rdata_q  <= rdata_d;
    end
  end

  assign bus.framen    = framen_q;
  assign bus.irdyn     = irdyn_q;
  assign bus.cmd_read  = read_q;
  assign bus.ad_mst    = ad_q;
  assign bus.ad_mst_oe = ad_oe_q;
  assign busy          = busy_q;
  assign done          = done_q;
  assign status        = status_q;
  assign rdata         = rdata_q;
endmodule
`default_nettype wire

// ---- pcitr_checker_sva.sv ----
// pcitr_checker: concurrent checks on the bus between master end and target end
// assumes one clock mclk and synchronous active-low rstn; sees the wires as plain inputs
`timescale 1ns/10ps
`default_nettype none
module pcitr_checker
  import pcitr_pkg::*;
(
  input wire logic              mclk,
  input wire logic              rstn,
  input wire logic              framen,
  input wire logic              irdyn,
  input wire logic              cmd_read,
  input wire logic              devseln,
  input wire logic              trdyn,
  input wire logic              stopn,
  input wire logic [DATA_W-1:0] ad_tgt,
  input wire logic              ad_tgt_oe,
  input wire logic              local_target_ready_n,
  input wire logic              local_target_disconnect_req_n,
  input wire logic              local_abort_req_n,
  input wire logic [DATA_W-1:0] local_read_data_in,
  input wire logic              local_transfer_strobe_n
);
  logic [4:0] wait_q;
  logic [4:0] wait_d;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // cycles of a transaction with no ready yet and no stop on the bus
  always_comb begin
    wait_d = wait_q;
    if (framen || !local_target_ready_n || !stopn) begin
      wait_d = 5'h00;
    end else if (wait_q != 5'h1f) begin
      wait_d = wait_q + 5'h01;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wait_q <= 5'h00;
    end else begin
      wait_q <= wait_d;
    end
  end

  sequence s_rd_ready;
    !framen && cmd_read && !devseln && !local_target_ready_n && local_abort_req_n;
  endsequence
  sequence s_disc_twice;
    (!framen && !devseln && !local_target_disconnect_req_n) ##1 !local_target_disconnect_req_n;
  endsequence
  sequence s_term_end;
    !stopn ##1 $rose(irdyn);
  endsequence

  a_claim_clk_four: assert property ($fell(framen) |-> ##2 devseln ##1 !devseln)
    else $error("devseln not first low in clock four");
  a_no_strobe_idle: assert property (local_target_ready_n |=> local_transfer_strobe_n)
    else $error("strobe after a cycle without ready");
  a_stop_after_disc: assert property (s_disc_twice |=> !stopn)
    else $error("stopn not low after two disconnect cycles");
  a_release_with_irdy: assert property (s_term_end |-> stopn && devseln)
    else $error("devseln or stopn held as irdyn rose");
  a_stop_end_irdy: assert property ($rose(stopn) |-> $rose(irdyn))
    else $error("stopn released apart from irdyn");
  a_abort_stop_holds: assert property (devseln && !stopn && !framen |=> !stopn)
    else $error("abort stopn dropped before framen rose");
  a_read_strobe_next: assert property (s_rd_ready |=> !local_transfer_strobe_n)
    else $error("read strobe missing after ready");
  a_read_trdy_two: assert property (s_rd_ready ##1 local_abort_req_n |=> !trdyn)
    else $error("trdyn not low two cycles after ready");
  a_read_ad_word: assert property (!trdyn && cmd_read && !framen
                                   |-> ad_tgt_oe && ad_tgt == $past(local_read_data_in))
    else $error("read word not on ad with trdyn");
  a_abort_next: assert property (!local_abort_req_n && !devseln |=> devseln && trdyn && !stopn)
    else $error("target abort not signalled after request");
  a_retry_timer: assert property (wait_q <= TMR_W'(RETRY_CLKS))
    else $error("no retry after waiting for ready");
endmodule
`default_nettype wire

// ---- test_pci_target_retry_abort.sv ----
// test_pci_target_retry_abort: master end and target end joined by the bus interface
// assumes one 25 MHz clock; the bench plays the target back-end and the master's user
`timescale 1ns/10ps
`default_nettype none
module test_pci_target_retry_abort;
  import pcitr_pkg::*;
  logic              mclk, rstn, req, req_read, busy, done, local_read_cycle, ph;
  logic              local_target_ready_n, local_target_disconnect_req_n, local_abort_req_n;
  logic              local_transfer_strobe_n;
  logic [1:0]        status;
  logic [DATA_W-1:0] req_wdata, rdata, local_read_data_in, local_write_data_out, wr_seen;
  int                miscompares, compares, k, strobes, cycles, mode;

  pcitr_bus_if bus_inst ();
  pcitr_master pcitr_master_inst (.mclk(mclk), .rstn(rstn), .bus(bus_inst), .req(req),
    .req_read(req_read), .req_addr(32'h0000_0010), .req_wdata(req_wdata), .busy(busy),
    .done(done), .status(status), .rdata(rdata));
  pcitr_target pcitr_target_inst (.mclk(mclk), .rstn(rstn), .bus(bus_inst),
    .local_target_ready_n(local_target_ready_n),
    .local_target_disconnect_req_n(local_target_disconnect_req_n),
    .local_abort_req_n(local_abort_req_n), .local_read_data_in(local_read_data_in),
    .local_transfer_strobe_n(local_transfer_strobe_n),
    .local_write_data_out(local_write_data_out), .local_read_cycle(local_read_cycle));
  pcitr_checker pcitr_checker_inst (.mclk(mclk), .rstn(rstn), .framen(bus_inst.framen),
    .irdyn(bus_inst.irdyn), .cmd_read(bus_inst.cmd_read), .devseln(bus_inst.devseln),
    .trdyn(bus_inst.trdyn), .stopn(bus_inst.stopn), .ad_tgt(bus_inst.ad_tgt),
    .ad_tgt_oe(bus_inst.ad_tgt_oe), .local_target_ready_n(local_target_ready_n),
    .local_target_disconnect_req_n(local_target_disconnect_req_n),
    .local_abort_req_n(local_abort_req_n), .local_read_data_in(local_read_data_in),
    .local_transfer_strobe_n(local_transfer_strobe_n));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // back-end: k counts the cycles of the transaction, cycle 1 being the first with framen low
  // modes: 0 complete, 1 disconnect before ready, 2 never ready, 3 abort before trdyn
  always @(negedge mclk) begin
    k = (bus_inst.framen === 1'b0) ? k + 1 : 0;
    if (k == 1) begin
      ph = 1'b0;
    end
    if (k == 4 && mode == 0 && !req_read) begin
      ph = 1'b1;
    end
    // a write keeps ready low after the bus ends so the buffered word drains
    local_target_ready_n = !((mode == 0 && k == 4) || ph ||
                             (mode == 3 && (k == 4 || k == 5)));
    local_target_disconnect_req_n = !(mode == 1 && (k == 4 || k == 5));
    // a single-word master ends on the first trdyn, so the abort must come before it
    local_abort_req_n = !(mode == 3 && k == (req_read ? 5 : 4));
    // read data is only good in the cycle after ready, so a wrong pipeline shows up
    local_read_data_in = (k == 5) ? req_wdata : ~req_wdata;
  end

  always @(posedge mclk) begin
    if (local_transfer_strobe_n === 1'b0) begin
      strobes++;
      wr_seen = local_write_data_out;
    end
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic check(input string what, input logic [DATA_W-1:0] exp,
                       input logic [DATA_W-1:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic do_reset();
    rstn = 1'b0;
    repeat (3) @(negedge mclk);
    rstn = 1'b1;
  endtask

  // one master request; exp_strb below zero skips the strobe count
  task automatic run(input logic rd, input int m, input logic [DATA_W-1:0] d,
                     input logic [1:0] exp_st, input int exp_strb);
    int n;
    @(negedge mclk);
    mode = m;
    req_read = rd;
    req_wdata = d;
    strobes = 0;
    req = 1'b1;
    @(negedge mclk);
    req = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 60) begin
      @(negedge mclk);
      n++;
    end
    check("done", 32'h0000_0001, {31'h0000_0000, done});
    check("status", {30'h0000_0000, exp_st}, {30'h0000_0000, status});
    check("busy", 32'h0000_0000, {31'h0000_0000, busy});
    check("read cycle", {31'h0000_0000, rd}, {31'h0000_0000, local_read_cycle});
    if (rd && exp_st === ST_NORMAL) begin
      check("rdata", d, rdata);
    end
    repeat (4) @(negedge mclk);
    if (exp_strb >= 0) begin
      check("strobes", DATA_W'(exp_strb), DATA_W'(strobes));
    end
    if (!rd && exp_st === ST_NORMAL) begin
      check("write data", d, wr_seen);
    end
  endtask

  task automatic report_and_stop();
    if (miscompares == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    rstn = 1'b0;
    req = 1'b0;
    req_read = 1'b1;
    req_wdata = 32'h0000_0000;
    local_read_data_in = 32'h0000_0000;
    local_target_ready_n = 1'b1;
    local_target_disconnect_req_n = 1'b1;
    local_abort_req_n = 1'b1;
    mode = 0;
    k = 0;
    ph = 1'b0;
    miscompares = 0;
    compares = 0;
    strobes = 0;
    cycles = 0;
    do_reset();
    run(1'b1, 0, 32'hA5C3_0001, ST_NORMAL, 1);
    run(1'b0, 0, 32'h3C5A_0002, ST_NORMAL, 1);
    run(1'b1, 1, 32'h0F0F_0003, ST_RETRY, 0);
    run(1'b0, 1, 32'hF0F0_0004, ST_RETRY, 0);
    run(1'b1, 2, 32'h1234_0005, ST_RETRY, 0);
    run(1'b0, 2, 32'h4321_0006, ST_RETRY, 0);
    run(1'b1, 3, 32'hBEEF_0007, ST_ABORT, 1);
    run(1'b0, 3, 32'hCAFE_0008, ST_ABORT, 0);
    // a second reset mid-run must leave both ends idle and ready for a new request
    do_reset();
    run(1'b0, 0, 32'h6996_0009, ST_NORMAL, 1);
    run(1'b1, 1, 32'h9669_000A, ST_RETRY, 0);
    report_and_stop();
  end
endmodule
`default_nettype wire
